// ---- hw/pis_pkg.sv ----
// Purpose: Shared constants and types of the PCI interrupt and status logic.
// Assumes: APB registers at word offsets; one clock domain.
// Notes:   Status layout is four error bits followed by four software bits.
package pis_pkg;

  // ****************************************************************
  // Status layout
  // ****************************************************************
  localparam int unsigned STAT_W      = 8;
  localparam int unsigned BIT_PARITY  = 0;
  localparam int unsigned BIT_SYSERR  = 1;
  localparam int unsigned BIT_MABORT  = 2;
  localparam int unsigned BIT_TABORT  = 3;
  localparam int unsigned SOFT_LSB    = 4;
  localparam logic [STAT_W-1:0] SOFT_MASK   = 8'hF0;
  localparam logic [STAT_W-1:0] STAT_RESET  = 8'h00;
  localparam logic [STAT_W-1:0] EN_RESET    = 8'h00;

  // ****************************************************************
  // APB register offsets
  // ****************************************************************
  localparam logic [7:0] OFS_STAT_SET     = 8'h00;
  localparam logic [7:0] OFS_STAT_CLR     = 8'h04;
  localparam logic [7:0] OFS_HOST_EN_SET  = 8'h08;
  localparam logic [7:0] OFS_HOST_EN_CLR  = 8'h0C;
  localparam logic [7:0] OFS_CPU_EN_SET   = 8'h10;
  localparam logic [7:0] OFS_CPU_EN_CLR   = 8'h14;
  localparam logic [7:0] OFS_HOOK_ID      = 8'h20;
  localparam logic [7:0] OFS_HOOK_CLASS   = 8'h24;
  localparam logic [7:0] OFS_HOOK_SUBSYS  = 8'h28;
  localparam logic [7:0] OFS_MIR_ID       = 8'h30;
  localparam logic [7:0] OFS_MIR_CMD      = 8'h34;
  localparam logic [7:0] OFS_MIR_CLASS    = 8'h38;
  localparam logic [7:0] OFS_MIR_SUBSYS   = 8'h3C;
  localparam logic [7:0] OFS_MIR_BAR0     = 8'h40;
  localparam int unsigned NUM_BAR         = 6;

  // ****************************************************************
  // Configuration space dword indexes
  // ****************************************************************
  localparam logic [3:0] CFG_ID     = 4'h0;
  localparam logic [3:0] CFG_CMD    = 4'h1;
  localparam logic [3:0] CFG_CLASS  = 4'h2;
  localparam logic [3:0] CFG_BAR0   = 4'h4;
  localparam logic [3:0] CFG_SUBSYS = 4'hB;

  // ****************************************************************
  // Reset values and power state
  // ****************************************************************
  // The identification default below is arbitrary.
  localparam logic [31:0] HOOK_ID_RESET     = 32'h1234_5678;
  localparam logic [31:0] HOOK_CLASS_RESET  = 32'h1180_0001;
  localparam logic [31:0] HOOK_SUBSYS_RESET = 32'h0000_0000;
  localparam logic [31:0] WORD_ZERO         = 32'h0000_0000;
  localparam logic [1:0]  PWR_D0            = 2'h0;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic data_parity;      // Data parity fault seen this cycle.
    logic master_read;      // Device masters a read.
    logic target_write;     // Device is target of a write.
    logic got_tabort;       // Target abort received as master.
    logic addr_parity;      // Address parity fault on the bus.
    logic master_abort;     // Own master cycle ended by master abort.
    logic sent_tabort;      // Device signalled a target abort.
  } pis_event_t;

  typedef struct packed {
    logic        valid;     // Configuration request present.
    logic        type0;     // Request is a type 0 cycle.
    logic        write;     // One for write.
    logic [3:0]  index;     // Dword index.
    logic [31:0] wdata;     // Write data.
  } pis_cfg_req_t;

endpackage : pis_pkg

// ---- hw/pis_enable_reg.sv ----
// Purpose: Hidden enable register reached only by write-one set and clear.
// Assumes: Set and clear masks are one-cycle pulses.
// Notes:   Set wins when a bit is set and cleared together.
`timescale 1ns/1ps
`default_nettype none
module pis_enable_reg
  import pis_pkg::*;
(
  input  wire logic              clock,    // Module clock.
  input  wire logic              rst_n,    // Asynchronous reset, active low.
  input  wire logic [STAT_W-1:0] set_mask, // Ones enable bits.
  input  wire logic [STAT_W-1:0] clr_mask, // Ones disable bits.
  output logic      [STAT_W-1:0] q         // Present enables.
);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= EN_RESET;
    end else begin
      q <= (q & ~clr_mask) | set_mask;
    end
  end

endmodule : pis_enable_reg
`default_nettype wire

// ---- hw/pis_top.sv ----
// Purpose: Status, interrupt enable and configuration hook logic of a PCI interface.
// Assumes: Event inputs come from logic on the same clock; pci_reset_n is a pin.
// Notes:   Registers are reached over APB; configuration space by type 0 requests.
//
// What this block does
// - On PCI reset, copy every hook register into its live configuration register.
// - Hooks start at defaults and software may overwrite them before the reset.
// - Parity status sets on data parity during own read or targeted write.
// - System status sets on target abort received or address parity fault.
// - Master abort status sets when own master cycle ends by master abort.
// - Target abort status sets when the device signals target abort.
// - Hidden host enable; write ones to its set port enable bits.
// - Reading the host enable set port returns the hidden host enables.
// - Writing ones to the host enable clear port disables those bits.
// - Reading the host enable clear port returns status AND host enables.
// - Host pin is driven low while any enabled status bit is set.
// - Host pin interrupts are disabled by default; the pin asserts only in the D0 power state.
// - Software status bits raise the host pin; clearing the bit removes it.
// - Hidden CPU enable; write ones to its set port enable bits.
// - Reading the CPU enable set port returns the hidden CPU enables.
// - Writing ones to the CPU enable clear port disables those bits.
// - Reading the CPU enable clear port returns status AND CPU enables.
// - CPU request is high while any status bit and its CPU enable are set.
// - Software bits written through the status set port raise the CPU request when their CPU enables are set.
// - Exactly one dedicated interrupt output goes to the local CPU.
// - The block makes no DMA request events.
// - Type 0 cycles reach configuration space; mirror writes update it.
`timescale 1ns/1ps
`default_nettype none
module pis_top
  import pis_pkg::*;
(
  input  wire logic                  clock,                // 250 MHz clock.
  input  wire logic                  rst_n,                // Async reset, active low.
  input  wire logic                  pci_reset_n,          // PCI reset pin, active low.
  input  wire logic [1:0]            power_state,          // Function power state.
  input  wire pis_pkg::pis_event_t   bus_event,            // Bus events, one-cycle pulses.
  input  wire pis_pkg::pis_cfg_req_t cfg_req,              // Configuration request.
  output logic                       cfg_ack,              // Configuration answer pulse.
  output logic      [31:0]           cfg_rdata,            // Configuration read data.
  input  wire logic                  psel,                 // APB select.
  input  wire logic                  penable,              // APB enable.
  input  wire logic                  pwrite,               // APB direction.
  input  wire logic [7:0]            paddr,                // APB byte address.
  input  wire logic [31:0]           pwdata,               // APB write data.
  output logic                       pready,               // APB ready.
  output logic      [31:0]           prdata,               // APB read data.
  output logic                       pslverr,              // APB error, unmapped address.
  output logic                       host_interrupt_pin_n, // Host pin level, low asserts.
  output logic                       host_interrupt_pin_oe,// High while pin is pulled low.
  output logic                       cpu_interrupt_request // Local CPU interrupt.
);
  import pis_pkg::*;

  // ****************************************************************
  // PCI reset pin synchroniser
  // ****************************************************************
  logic [2:0] prst_sync;
  logic       pci_reset_active;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prst_sync        <= 3'h7;
      pci_reset_active <= 1'b0;
    end else begin
      prst_sync <= {prst_sync[1:0], pci_reset_n};
      if (prst_sync[2] == prst_sync[1]) begin
        pci_reset_active <= ~prst_sync[1];
      end
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  logic              apb_access;
  logic              apb_wr;
  logic              mapped;
  logic [STAT_W-1:0] wr_byte;
  logic [STAT_W-1:0] host_set;
  logic [STAT_W-1:0] host_clr;
  logic [STAT_W-1:0] cpu_set;
  logic [STAT_W-1:0] cpu_clr;
  logic [STAT_W-1:0] host_en;
  logic [STAT_W-1:0] cpu_en;
  logic [STAT_W-1:0] status;
  logic [STAT_W-1:0] stat_set;
  logic [STAT_W-1:0] stat_clr;
  logic [STAT_W-1:0] evt_bits;
  logic [31:0]       next_rdata;
  logic [31:0]       hook_id;
  logic [31:0]       hook_class;
  logic [31:0]       hook_subsys;
  logic [31:0]       live_id;
  logic [31:0]       live_cmd;
  logic [31:0]       live_class;
  logic [31:0]       live_subsys;
  logic [31:0]       live_bar [NUM_BAR];
  logic              bar_hit;
  logic              mir_hit;
  logic [2:0]        bar_sel;

  assign apb_access = psel & penable;
  assign apb_wr     = apb_access & pready & pwrite;
  assign wr_byte    = pwdata[STAT_W-1:0];
  assign bar_hit    = (paddr >= OFS_MIR_BAR0) && (paddr < OFS_MIR_BAR0 + 8'h18) &&
                      (paddr[1:0] == 2'h0);
  assign bar_sel    = 3'((paddr - OFS_MIR_BAR0) >> 2);
  assign mir_hit    = bar_hit || (paddr inside {OFS_MIR_ID, OFS_MIR_CMD, OFS_MIR_CLASS,
                                               OFS_MIR_SUBSYS});

  always_comb begin
    next_rdata = WORD_ZERO;
    mapped     = 1'b1;
    if (bar_hit) begin
      next_rdata = live_bar[bar_sel];
    end else begin
      case (paddr)
        OFS_STAT_SET, OFS_STAT_CLR: next_rdata = {24'h00_0000, status};
        OFS_HOST_EN_SET: next_rdata = {24'h00_0000, host_en};
        OFS_HOST_EN_CLR: next_rdata = {24'h00_0000, status & host_en};
        OFS_CPU_EN_SET:  next_rdata = {24'h00_0000, cpu_en};
        OFS_CPU_EN_CLR:  next_rdata = {24'h00_0000, status & cpu_en};
        OFS_HOOK_ID:     next_rdata = hook_id;
        OFS_HOOK_CLASS:  next_rdata = hook_class;
        OFS_HOOK_SUBSYS: next_rdata = hook_subsys;
        OFS_MIR_ID:      next_rdata = live_id;
        OFS_MIR_CMD:     next_rdata = live_cmd;
        OFS_MIR_CLASS:   next_rdata = live_class;
        OFS_MIR_SUBSYS:  next_rdata = live_subsys;
        default:         mapped     = 1'b0;
      endcase
    end
  end

  // Ready rises one cycle into the access phase, so every transfer takes 3 cycles.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= WORD_ZERO;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_access & ~pready;
      if (apb_access && !pready) begin
        prdata  <= pwrite ? WORD_ZERO : next_rdata;
        pslverr <= ~mapped;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Status and hidden enables
  // ****************************************************************
  always_comb begin
    host_set = {STAT_W{1'b0}};
    host_clr = {STAT_W{1'b0}};
    cpu_set  = {STAT_W{1'b0}};
    cpu_clr  = {STAT_W{1'b0}};
    stat_set = {STAT_W{1'b0}};
    stat_clr = {STAT_W{1'b0}};
    if (apb_wr) begin
      case (paddr)
        OFS_STAT_SET:    stat_set = wr_byte;
        OFS_STAT_CLR:    stat_clr = wr_byte;
        OFS_HOST_EN_SET: host_set = wr_byte;
        OFS_HOST_EN_CLR: host_clr = wr_byte;
        OFS_CPU_EN_SET:  cpu_set  = wr_byte;
        OFS_CPU_EN_CLR:  cpu_clr  = wr_byte;
        default: ;
      endcase
    end
  end

  always_comb begin
    evt_bits             = {STAT_W{1'b0}};
    evt_bits[BIT_PARITY] = bus_event.data_parity &
                           (bus_event.master_read | bus_event.target_write);
    evt_bits[BIT_SYSERR] = bus_event.got_tabort | bus_event.addr_parity;
    evt_bits[BIT_MABORT] = bus_event.master_abort;
    evt_bits[BIT_TABORT] = bus_event.sent_tabort;
  end

  // An event or a set write in the same cycle as a clear wins over it.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status <= STAT_RESET;
    end else begin
      status <= (status & ~stat_clr) | stat_set | evt_bits;
    end
  end

  pis_enable_reg u_host_en (
    .clock    (clock),
    .rst_n    (rst_n),
    .set_mask (host_set),
    .clr_mask (host_clr),
    .q        (host_en)
  );

  pis_enable_reg u_cpu_en (
    .clock    (clock),
    .rst_n    (rst_n),
    .set_mask (cpu_set),
    .clr_mask (cpu_clr),
    .q        (cpu_en)
  );

  // ****************************************************************
  // Interrupt outputs
  // ****************************************************************
  // The block has no DMA event output at all.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      host_interrupt_pin_n  <= 1'b1;
      host_interrupt_pin_oe <= 1'b0;
      cpu_interrupt_request <= 1'b0;
    end else begin
      host_interrupt_pin_oe <= (|(status & host_en)) && (power_state == PWR_D0);
      host_interrupt_pin_n  <= ~((|(status & host_en)) && (power_state == PWR_D0));
      cpu_interrupt_request <= |(status & cpu_en);
    end
  end

  // ****************************************************************
  // Hook, live and mirror configuration registers
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hook_id     <= HOOK_ID_RESET;
      hook_class  <= HOOK_CLASS_RESET;
      hook_subsys <= HOOK_SUBSYS_RESET;
    end else if (apb_wr) begin
      case (paddr)
        OFS_HOOK_ID:     hook_id     <= pwdata;
        OFS_HOOK_CLASS:  hook_class  <= pwdata;
        OFS_HOOK_SUBSYS: hook_subsys <= pwdata;
        default: ;
      endcase
    end
  end

  logic cfg_hit;
  logic cfg_bar_hit;
  logic [2:0] cfg_bar_sel;
  assign cfg_hit     = cfg_req.valid & cfg_req.type0;
  assign cfg_bar_hit = (cfg_req.index >= CFG_BAR0) && (cfg_req.index < CFG_BAR0 + 4'h6);
  assign cfg_bar_sel = 3'(cfg_req.index - CFG_BAR0);

  // PCI reset reloads the identity words; mirror writes come next, host writes last.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      live_id     <= HOOK_ID_RESET;
      live_cmd    <= WORD_ZERO;
      live_class  <= HOOK_CLASS_RESET;
      live_subsys <= HOOK_SUBSYS_RESET;
      for (int i = 0; i < NUM_BAR; i++) begin
        live_bar[i] <= WORD_ZERO;
      end
    end else if (pci_reset_active) begin
      live_id     <= hook_id;
      live_class  <= hook_class;
      live_subsys <= hook_subsys;
      live_cmd    <= WORD_ZERO;
      for (int i = 0; i < NUM_BAR; i++) begin
        live_bar[i] <= WORD_ZERO;
      end
    end else if (apb_wr && mir_hit) begin
      if (bar_hit) begin
        live_bar[bar_sel] <= pwdata;
      end
      case (paddr)
        OFS_MIR_ID:     live_id     <= pwdata;
        OFS_MIR_CMD:    live_cmd    <= pwdata;
        OFS_MIR_CLASS:  live_class  <= pwdata;
        OFS_MIR_SUBSYS: live_subsys <= pwdata;
        default: ;
      endcase
    end else if (cfg_hit && cfg_req.write) begin
      if (cfg_bar_hit) begin
        live_bar[cfg_bar_sel] <= cfg_req.wdata;
      end
      if (cfg_req.index == CFG_CMD) begin
        live_cmd <= cfg_req.wdata;
      end
    end
  end

  // Configuration answers come one cycle after a type 0 request; others get none.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ack   <= 1'b0;
      cfg_rdata <= WORD_ZERO;
    end else begin
      cfg_ack <= cfg_hit;
      if (cfg_hit && !cfg_req.write) begin
        if (cfg_bar_hit) begin
          cfg_rdata <= live_bar[cfg_bar_sel];
        end else begin
          case (cfg_req.index)
            CFG_ID:     cfg_rdata <= live_id;
            CFG_CMD:    cfg_rdata <= live_cmd;
            CFG_CLASS:  cfg_rdata <= live_class;
            CFG_SUBSYS: cfg_rdata <= live_subsys;
            default:    cfg_rdata <= WORD_ZERO;
          endcase
        end
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_parity_sets: assert property (
    bus_event.data_parity && bus_event.master_read |=> status[BIT_PARITY])
    else $error("Parity status not set.");
  a_syserr_sets: assert property (
    bus_event.addr_parity |=> status[BIT_SYSERR])
    else $error("System error status not set.");
  a_mabort_sets: assert property (
    bus_event.master_abort |=> status[BIT_MABORT])
    else $error("Master abort status not set.");
  a_tabort_sets: assert property (
    bus_event.sent_tabort |=> status[BIT_TABORT])
    else $error("Target abort status not set.");
  a_status_sticky: assert property (
    status[BIT_MABORT] && !(apb_wr && paddr == OFS_STAT_CLR) |=> status[BIT_MABORT])
    else $error("Status bit dropped without a clear.");
  a_host_pin_level: assert property (
    (|(status & host_en)) && power_state == PWR_D0 |=>
      !host_interrupt_pin_n && host_interrupt_pin_oe)
    else $error("Host pin not asserted for enabled status.");
  a_host_pin_idle: assert property (
    !(|(status & host_en)) |=> host_interrupt_pin_n && !host_interrupt_pin_oe)
    else $error("Host pin asserted without cause.");
  a_cpu_irq_follow: assert property (
    cpu_interrupt_request == $past(|(status & cpu_en)))
    else $error("CPU request does not follow enabled status.");
  a_soft_force: assert property (
    apb_wr && paddr == OFS_STAT_SET && |(wr_byte & SOFT_MASK & cpu_en) |=>
      ##1 cpu_interrupt_request)
    else $error("Software bit did not force CPU request.");
  a_host_clr_read: assert property (
    apb_access && !pready && !pwrite && paddr == OFS_HOST_EN_CLR |=>
      prdata == {24'h00_0000, $past(status & host_en)})
    else $error("Host clear port read is wrong.");
  a_hook_latch: assert property (
    pci_reset_active |=> live_class == $past(hook_class))
    else $error("Hook not copied on PCI reset.");
  a_apb_ready: assert property (
    apb_access && !pready |=> pready ##1 !pready)
    else $error("APB ready not a single pulse.");

  c_host_irq: cover property (host_interrupt_pin_oe);
  c_cpu_irq: cover property (cpu_interrupt_request ##1 !cpu_interrupt_request);
  c_pci_reset: cover property (pci_reset_active ##1 !pci_reset_active);
  c_cfg_write: cover property (cfg_hit && cfg_req.write);

endmodule : pis_top
`default_nettype wire

// ---- testbench/pis_host_model.sv ----
// Purpose: Far-side model that raises bus events and issues config cycles.
// Assumes: Tasks are entered just after a rising clock edge.
// Notes:   A released request shows the inverse of its last value.
`timescale 1ns/1ps
`default_nettype none
module pis_host_model
  import pis_pkg::*;
(
  input  wire logic                 clock,     // Module clock.
  output var pis_pkg::pis_event_t   bus_event, // Event pulses.
  output var pis_pkg::pis_cfg_req_t cfg_req,   // Config request.
  input  wire logic                 cfg_ack,   // Config answer.
  input  wire logic [31:0]          cfg_rdata  // Config read data.
);
  initial begin
    bus_event = '0;
    cfg_req = '0;
  end

  task automatic pulse(input pis_event_t e);
    bus_event <= e;
    @(posedge clock);
    bus_event <= '0;
  endtask : pulse

  task automatic access(input logic t0, input logic w, input logic [3:0] i,
                        input logic [31:0] d, output logic [31:0] r, output logic ack);
    int n;
    cfg_req <= '{valid: 1'b1, type0: t0, write: w, index: i, wdata: d};
    @(posedge clock);
    cfg_req <= '{valid: 1'b0, type0: ~t0, write: ~w, index: ~i, wdata: ~d};
    ack = 1'b0;
    r = '0;
    n = 0;
    while (ack !== 1'b1 && n < 4) begin
      @(posedge clock);
      ack = cfg_ack;
      r = cfg_rdata;
      n++;
    end
  endtask : access
endmodule : pis_host_model
`default_nettype wire

// ---- testbench/pis_top_tb.sv ----
// Purpose: Self-checking bench for the interrupt and status logic.
// Assumes: APB master drives right after rising edges.
// Notes:   Pins settle two edges after the status write.
`timescale 1ns/1ps
`default_nettype none
module pis_top_tb;
  import pis_pkg::*;
  typedef struct {pis_event_t ev; logic [7:0] st;} pis_row_t;
  logic                 clock, rst_n, pci_reset_n, psel, penable, pwrite;
  logic                 pready, pslverr, pin_n, pin_oe, cpu_req, cfg_ack, ca, er;
  logic [1:0]           power_state;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata, cfg_rdata, cr, rd;
  pis_event_t           bus_event;
  pis_cfg_req_t         cfg_req;
  int                   mismatches = 0;
  int                   checks = 0;
  int                   cycles = 0;
  pis_row_t rows [7] = '{'{7'h60, 8'h01}, '{7'h50, 8'h01}, '{7'h40, 8'h00},
    '{7'h08, 8'h02}, '{7'h04, 8'h02}, '{7'h02, 8'h04}, '{7'h01, 8'h08}};

  pis_top dut (.clock(clock), .rst_n(rst_n), .pci_reset_n(pci_reset_n),
    .power_state(power_state), .bus_event(bus_event), .cfg_req(cfg_req),
    .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .host_interrupt_pin_n(pin_n), .host_interrupt_pin_oe(pin_oe),
    .cpu_interrupt_request(cpu_req));
  pis_host_model host (.clock(clock), .bus_event(bus_event), .cfg_req(cfg_req),
    .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));

  always #2 clock = ~clock;

  // ****************************************************************
  // Bus and check tasks
  // ****************************************************************
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) mismatches++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdc

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      results();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    pci_reset_n = 1'b1;
    power_state = PWR_D0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk("pin_n", 32'h1, pin_n);
    chk("cpu_req", 32'h0, cpu_req);
    apb(1'b1, OFS_CPU_EN_SET, 32'hF);
    foreach (rows[i]) begin
      host.pulse(rows[i].ev);
      repeat (8) @(posedge clock);
      rdc("status", OFS_STAT_SET, rows[i].st);
      chk("cpu_req", rows[i].st != 0, cpu_req);
      apb(1'b1, OFS_STAT_CLR, 32'hFF);
    end
    apb(1'b1, OFS_CPU_EN_CLR, 32'hFF);
    rdc("cpu_en", OFS_CPU_EN_SET, 32'h0);
    apb(1'b1, OFS_HOST_EN_SET, 32'hF);
    rdc("host_en", OFS_HOST_EN_SET, 32'hF);
    apb(1'b1, OFS_HOST_EN_CLR, 32'h5);
    rdc("host_en", OFS_HOST_EN_SET, 32'hA);
    apb(1'b1, OFS_HOST_EN_SET, 32'h10);
    apb(1'b1, OFS_CPU_EN_SET, 32'h30);
    rdc("cpu_en", OFS_CPU_EN_SET, 32'h30);
    apb(1'b1, OFS_STAT_SET, 32'h30);
    @(posedge clock);
    chk("pin_n", 32'h0, pin_n);
    chk("pin_oe", 32'h1, pin_oe);
    chk("cpu_req", 32'h1, cpu_req);
    rdc("host_src", OFS_HOST_EN_CLR, 32'h10);
    rdc("cpu_src", OFS_CPU_EN_CLR, 32'h30);
    power_state <= 2'h3;
    repeat (3) @(posedge clock);
    chk("pin_n", 32'h1, pin_n);
    power_state <= PWR_D0;
    apb(1'b1, OFS_STAT_CLR, 32'h10);
    @(posedge clock);
    chk("pin_n", 32'h1, pin_n);
    chk("cpu_req", 32'h1, cpu_req);
    apb(1'b1, OFS_CPU_EN_CLR, 32'h20);
    @(posedge clock);
    chk("cpu_req", 32'h0, cpu_req);
    rdc("unmapped", 8'h1C, 32'h0);
    chk("slverr", 32'h1, er);
    rdc("hook_id", OFS_HOOK_ID, HOOK_ID_RESET);
    apb(1'b1, OFS_HOOK_ID, 32'hCAFE_0001);
    pci_reset_n <= 1'b0;
    repeat (6) @(posedge clock);
    pci_reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    host.access(1'b1, 1'b0, CFG_ID, 32'h0, cr, ca);
    chk("cfg_id", 32'hCAFE_0001, cr);
    chk("cfg_ack", 32'h1, ca);
    rdc("live_id", OFS_MIR_ID, 32'hCAFE_0001);
    rdc("status", OFS_STAT_SET, 32'h20);
    apb(1'b1, OFS_MIR_CMD, 32'h6);
    host.access(1'b1, 1'b0, CFG_CMD, 32'h0, cr, ca);
    chk("cfg_cmd", 32'h6, cr);
    host.access(1'b1, 1'b1, CFG_BAR0, 32'h1234_0000, cr, ca);
    rdc("bar0", OFS_MIR_BAR0, 32'h1234_0000);
    host.access(1'b0, 1'b0, CFG_ID, 32'h0, cr, ca);
    chk("cfg_ack", 32'h0, ca);
    apb(1'b1, OFS_STAT_SET, 32'h10);
    @(posedge clock);
    chk("cpu_req", 32'h1, cpu_req);
    chk("pin_n", 32'h0, pin_n);
    rst_n <= 1'b0;
    @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk("cpu_req", 32'h0, cpu_req);
    chk("pin_n", 32'h1, pin_n);
    chk("pin_oe", 32'h0, pin_oe);
    rdc("status", OFS_STAT_SET, 32'h0);
    rdc("cpu_en", OFS_CPU_EN_SET, 32'h0);
    rdc("host_en", OFS_HOST_EN_SET, 32'h0);
    results();
  end
endmodule : pis_top_tb
`default_nettype wire
